// ### ubr_pkg.sv
// constants, register indices and field positions of the serial bit-rate generator
package ubr_pkg;

   // ----------------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ----------------------------------------------------------------------
   localparam logic [7:0] IDX_RATE_RELOAD = 8'h9a;
   localparam logic [7:0] IDX_RATE_CTRL = 8'h9b;
   localparam logic [7:0] IDX_UART_MODE = 8'h9c;
   localparam logic [7:0] IDX_POWER_CTRL = 8'h9d;
   localparam logic [7:0] IDX_T2_CTRL = 8'h9e;
   localparam logic [7:0] IDX_T2_RELOAD_LOW = 8'h9f;
   localparam logic [7:0] IDX_T2_RELOAD_HIGH = 8'ha0;
   localparam logic [7:0] IDX_RATE_COUNT = 8'ha1;
   localparam logic [7:0] IDX_T2_COUNT_LOW = 8'ha2;
   localparam logic [7:0] IDX_T2_COUNT_HIGH = 8'ha3;

   // ----------------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------------
   localparam int RC_MODE0_SRC = 0;
   localparam int RC_SPEED = 1;
   localparam int RC_RX_SEL = 2;
   localparam int RC_TX_SEL = 3;
   localparam int RC_RUN = 4;
   localparam int UM_MODE_LO = 0;
   localparam int UM_MODE_HI = 1;
   localparam int UM_NINTH_TX_BIT = 2;
   localparam int UM_FAST = 3;
   localparam int PC_BAUD_DOUBLER = 7;
   localparam int T2_RUN = 0;
   localparam int T2_TX_SEL = 4;
   localparam int T2_RX_SEL = 5;

   // ----------------------------------------------------------------------
   // reset values and counter limits
   // ----------------------------------------------------------------------
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [4:0] RST_RATE_CTRL = 5'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [7:0] RATE_GEN_FULL = 8'hff;
   localparam logic [15:0] T2_FULL = 16'hffff;
   localparam logic [2:0] SLOW_LAST = 3'h5;
   localparam logic [1:0] MODE_SHIFT = 2'h0;
   localparam logic [1:0] MODE_FIXED9 = 2'h2;
   // dividers hold "divisor minus one"
   localparam logic [4:0] DIV1 = 5'h00;
   localparam logic [4:0] DIV2 = 5'h01;
   localparam logic [4:0] DIV3 = 5'h02;
   localparam logic [4:0] DIV4 = 5'h03;
   localparam logic [4:0] DIV6 = 5'h05;
   localparam logic [4:0] DIV16 = 5'h0f;
   localparam logic [4:0] DIV32 = 5'h1f;
   localparam logic [4:0] CNT_ZERO = 5'h00;

   typedef struct packed {
      logic [7:0] rate_reload;
      logic [4:0] rate_ctrl;
      logic [3:0] uart_mode;
      logic baud_doubler;
      logic [2:0] t2_ctrl;
      logic [15:0] t2_reload;
      logic [7:0] rate_cnt;
      logic [2:0] slow_cnt;
      logic [15:0] t2_cnt;
      logic [4:0] sync_cnt;
      logic [4:0] tx_cnt;
      logic [4:0] rx_cnt;
      logic wr_pend;
      logic [7:0] wr_idx;
      logic [7:0] rdata;
      logic tx_tick;
      logic rx_tick;
   } ubr_state_t;

endpackage : ubr_pkg

// ### ubr_rate_gen.sv
// serial port bit-rate generator with its ahb-lite register slave
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps

// Behaviour
// - in mode 0 with the ninth transmit bit set, the shift clock is timer 1 overflow over 4, over 2 when doubled.
// - in modes 1 and 3 on timer 1 the bit rate is timer 1 overflow over 32, over 16 when doubled.
// - with timer 1 auto-reloading, its prescaled overflow feeds the same divide by 32 or 16.
// - the timer 2 transmit and receive selects route timer 2 to each direction independently.
// - timer 2 in rate mode reloads its 16-bit counter from the software reload value on rollover.
// - timer 2 sourced bit rate is its overflow rate over 16.
// - timer 2 in rate mode ignores the timer prescale and its own double speed setting.
// - a dedicated 8-bit reloading up-counter serves as the internal rate generator.
// - on overflow from all ones the internal generator loads the reload value.
// - the internal generator counts only while its run bit is set.
// - slow speed advances it every sixth system clock, fast speed every clock.
// - in modes 1 and 3 the internal generator ignores the prescale but its rate is over 32, or 16 when doubled.
// - the internal generator selects override the timer selects per direction.
// - the mode 0 source bit picks the internal generator instead of the fixed or timer 1 clock.
// - the baud doubler is bit 7 of the power control register and scales every rate except the timer 2 sourced ones.
module ubr_rate_gen
   import ubr_pkg::*;
(
   input wire logic ref_clk, // system clock
   input wire logic rst, // synchronous reset, active high
   input wire logic hsel, // ahb slave select
   input wire logic [31:0] haddr, // ahb address
   input wire logic [1:0] htrans, // ahb transfer type
   input wire logic hwrite, // ahb write
   input wire logic [2:0] hsize, // ahb size, words only
   input wire logic [31:0] hwdata, // ahb write data
   input wire logic hready, // ahb bus ready
   output logic hreadyout, // ahb slave ready
   output logic hresp, // ahb response, always okay
   output logic [31:0] hrdata, // ahb read data
   input wire logic t1_ovf, // timer 1 overflow pulse
   output logic tx_tick, // transmit bit-rate pulse
   output logic rx_tick // receive bit-rate pulse
);

   ubr_state_t q, n;

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   // advance a divider on an event; returns {terminal pulse, next count}
   function automatic logic [5:0] ubr_div_step(input logic [4:0] cnt, input logic ev,
                                               input logic [4:0] last);
      logic [5:0] r;
      r = {1'b0, cnt};
      if (ev) begin
         if (cnt >= last) begin
            r = {1'b1, CNT_ZERO};
         end else begin
            r = {1'b0, cnt + 5'h01};
         end
      end
      return r;
   endfunction : ubr_div_step

   function automatic logic [7:0] ubr_read(input ubr_state_t s, input logic [7:0] idx);
      logic [7:0] r;
      r = RST_BYTE;
      case (idx)
         IDX_RATE_RELOAD: r = s.rate_reload;
         IDX_RATE_CTRL: r = {3'h0, s.rate_ctrl};
         IDX_UART_MODE: r = {4'h0, s.uart_mode};
         IDX_POWER_CTRL: r = {s.baud_doubler, 7'h00};
         IDX_T2_CTRL: r = {2'h0, s.t2_ctrl[2:1], 3'h0, s.t2_ctrl[0]};
         IDX_T2_RELOAD_LOW: r = s.t2_reload[7:0];
         IDX_T2_RELOAD_HIGH: r = s.t2_reload[15:8];
         IDX_RATE_COUNT: r = s.rate_cnt;
         IDX_T2_COUNT_LOW: r = s.t2_cnt[7:0];
         IDX_T2_COUNT_HIGH: r = s.t2_cnt[15:8];
         default: r = RST_BYTE;
      endcase
      return r;
   endfunction : ubr_read

   logic addr_ok;
   logic take;
   logic rg_run, rg_fast, rg_adv, rg_ovf, slow_pulse;
   logic t2_active, t2_ovf;
   logic [1:0] mode;
   logic [5:0] sync_r, tx_r, rx_r;
   logic sync_ev, tx_ev, rx_ev;
   logic [4:0] sync_last, tx_last, rx_last;
   logic [7:0] wb;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = {24'h000000, q.rdata};
   assign tx_tick = q.tx_tick;
   assign rx_tick = q.rx_tick;

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb begin
      n = q;
      wb = hwdata[7:0];
      addr_ok = (haddr[31:10] == 22'h000000);
      take = hsel && htrans[1] && hready;
      mode = q.uart_mode[UM_MODE_HI:UM_MODE_LO];

      // register writes land in the data phase
      n.wr_pend = take && hwrite && addr_ok;
      n.wr_idx = haddr[9:2];
      if (q.wr_pend) begin
         case (q.wr_idx)
            IDX_RATE_RELOAD: n.rate_reload = wb;
            IDX_RATE_CTRL: n.rate_ctrl = wb[4:0];
            IDX_UART_MODE: n.uart_mode = wb[3:0];
            IDX_POWER_CTRL: n.baud_doubler = wb[PC_BAUD_DOUBLER];
            IDX_T2_CTRL: n.t2_ctrl = {wb[T2_RX_SEL], wb[T2_TX_SEL], wb[T2_RUN]};
            IDX_T2_RELOAD_LOW: n.t2_reload[7:0] = wb;
            IDX_T2_RELOAD_HIGH: n.t2_reload[15:8] = wb;
            default: n = n;
         endcase
      end

      // internal rate generator
      rg_run = q.rate_ctrl[RC_RUN];
      rg_fast = q.rate_ctrl[RC_SPEED];
      slow_pulse = (q.slow_cnt == SLOW_LAST);
      n.slow_cnt = slow_pulse ? 3'h0 : q.slow_cnt + 3'h1;
      rg_adv = rg_run && (rg_fast || slow_pulse);
      rg_ovf = rg_adv && (q.rate_cnt == RATE_GEN_FULL);
      if (rg_ovf) begin
         n.rate_cnt = q.rate_reload;
      end else if (rg_adv) begin
         n.rate_cnt = q.rate_cnt + 8'h01;
      end

      // timer 2 rate mode counts every clock: prescale and double speed do not apply
      t2_active = q.t2_ctrl[0] && (q.t2_ctrl[1] || q.t2_ctrl[2]);
      t2_ovf = t2_active && (q.t2_cnt == T2_FULL);
      if (t2_ovf) begin
         n.t2_cnt = q.t2_reload;
      end else if (t2_active) begin
         n.t2_cnt = q.t2_cnt + 16'h0001;
      end

      // mode 0 and mode 2 share one divider feeding both directions
      sync_ev = 1'b1;
      if (mode == MODE_FIXED9) begin
         sync_last = q.baud_doubler ? DIV16 : DIV32;
      end else if (q.rate_ctrl[RC_MODE0_SRC]) begin
         sync_ev = rg_ovf;
         sync_last = q.baud_doubler ? DIV1 : DIV2;
      end else if (q.uart_mode[UM_NINTH_TX_BIT]) begin
         sync_ev = t1_ovf;
         sync_last = q.baud_doubler ? DIV2 : DIV4;
      end else if (q.uart_mode[UM_FAST]) begin
         sync_last = q.baud_doubler ? DIV2 : DIV4;
      end else begin
         sync_last = q.baud_doubler ? DIV3 : DIV6;
      end

      // modes 1 and 3: per-direction source
      // internal generator wins over timer selects
      if (q.rate_ctrl[RC_TX_SEL]) begin
         tx_ev = rg_ovf;
         tx_last = q.baud_doubler ? DIV16 : DIV32;
      end else if (q.t2_ctrl[1]) begin
         tx_ev = t2_ovf;
         tx_last = DIV16;
      end else begin
         tx_ev = t1_ovf;
         tx_last = q.baud_doubler ? DIV16 : DIV32;
      end
      if (q.rate_ctrl[RC_RX_SEL]) begin
         rx_ev = rg_ovf;
         rx_last = q.baud_doubler ? DIV16 : DIV32;
      end else if (q.t2_ctrl[2]) begin
         rx_ev = t2_ovf;
         rx_last = DIV16;
      end else begin
         rx_ev = t1_ovf;
         rx_last = q.baud_doubler ? DIV16 : DIV32;
      end

      sync_r = ubr_div_step(q.sync_cnt, sync_ev, sync_last);
      tx_r = ubr_div_step(q.tx_cnt, tx_ev, tx_last);
      rx_r = ubr_div_step(q.rx_cnt, rx_ev, rx_last);
      n.sync_cnt = sync_r[4:0];
      n.tx_cnt = tx_r[4:0];
      n.rx_cnt = rx_r[4:0];
      if ((mode == MODE_SHIFT) || (mode == MODE_FIXED9)) begin
         n.tx_tick = sync_r[5];
         n.rx_tick = sync_r[5];
      end else begin
         n.tx_tick = tx_r[5];
         n.rx_tick = rx_r[5];
      end

      // read data captured at the address phase, after any write landing now
      n.rdata = (take && !hwrite && addr_ok) ? ubr_read(n, haddr[9:2]) : RST_BYTE;

      if (rst) begin
         n.rate_reload = RST_BYTE;
         n.rate_ctrl = RST_RATE_CTRL;
         n.uart_mode = 4'h0;
         n.baud_doubler = 1'b0;
         n.t2_ctrl = 3'h0;
         n.t2_reload = RST_WORD;
         n.rate_cnt = RST_BYTE;
         n.slow_cnt = 3'h0;
         n.t2_cnt = RST_WORD;
         n.sync_cnt = CNT_ZERO;
         n.tx_cnt = CNT_ZERO;
         n.rx_cnt = CNT_ZERO;
         n.wr_pend = 1'b0;
         n.wr_idx = RST_BYTE;
         n.rdata = RST_BYTE;
         n.tx_tick = 1'b0;
         n.rx_tick = 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      q <= n;
   end

endmodule : ubr_rate_gen

// ### ubr_rate_gen_props.sv
// port checker of the serial bit-rate generator
`timescale 1ns/1ps
module ubr_rate_gen_chk
   import ubr_pkg::*;
(
   input wire logic ref_clk, // system clock
   input wire logic rst, // synchronous reset
   input wire logic hsel, // ahb select
   input wire logic [31:0] haddr, // ahb address
   input wire logic [1:0] htrans, // ahb transfer type
   input wire logic hwrite, // ahb write
   input wire logic [31:0] hwdata, // ahb write data
   input wire logic hready, // ahb bus ready
   input wire logic hreadyout, // slave ready
   input wire logic hresp, // slave response
   input wire logic [31:0] hrdata, // read data
   input wire logic t1_ovf, // timer 1 overflow
   input wire logic tx_tick // transmit tick
);
   // ------------------------------------------------------------
   // shadow of the configuration written over the bus
   // ------------------------------------------------------------
   logic wp_q, rp_q, hit_q, db_q, t2tx_q;
   logic [7:0] ix_q, rl_q, qc_q;
   logic [4:0] rc_q;
   logic [3:0] um_q;
   wire take = hsel && htrans[1] && hready && !rst;
   always_ff @(posedge ref_clk) begin
      wp_q <= take && hwrite;
      rp_q <= take && !hwrite;
      hit_q <= haddr[31:10] == 22'h0;
      ix_q <= haddr[9:2];
      // rates are only judged once the configuration has stopped moving
      qc_q <= (rst || wp_q) ? 8'h00 : qc_q + {7'h0, qc_q != 8'hff};
      if (rst) begin
         rl_q <= RST_BYTE;
         rc_q <= RST_RATE_CTRL;
         um_q <= 4'h0;
         db_q <= 1'b0;
         t2tx_q <= 1'b0;
      end else if (wp_q && hit_q) begin
         if (ix_q == IDX_RATE_RELOAD) rl_q <= hwdata[7:0];
         if (ix_q == IDX_RATE_CTRL) rc_q <= hwdata[4:0];
         if (ix_q == IDX_UART_MODE) um_q <= hwdata[3:0];
         if (ix_q == IDX_POWER_CTRL) db_q <= hwdata[PC_BAUD_DOUBLER];
         if (ix_q == IDX_T2_CTRL) t2tx_q <= hwdata[T2_TX_SEL];
      end
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   a_ready_high:
      assert property (hreadyout) else $error("slave inserted a wait state");
   a_resp_okay:
      assert property (!hresp) else $error("slave gave an error response");
   a_rdata_idle:
      assert property (!(take && !hwrite) |=> hrdata == 32'h0) else $error("read data not cleared");
   a_reload_readback:
      assert property (rp_q && hit_q && ix_q == IDX_RATE_RELOAD |-> hrdata == {24'h0, rl_q})
         else $error("reload value read back wrong");
   a_ctrl_readback:
      assert property (rp_q && hit_q && ix_q == IDX_RATE_CTRL |-> hrdata == {27'h0, rc_q})
         else $error("rate control read back wrong");
   a_mode2_period:
      assert property (tx_tick && um_q[1:0] == MODE_FIXED9 && !db_q && qc_q >= 8'd40
         |-> ##32 (tx_tick || qc_q < 8'd32)) else $error("fixed mode period not 32");
   a_mode0_fast:
      assert property (tx_tick && um_q == 4'h8 && !rc_q[RC_MODE0_SRC] && !db_q && qc_q >= 8'd20
         |=> !tx_tick [*3] ##1 tx_tick) else $error("fast shift clock not every 4");
   a_t1_cause:
      assert property (tx_tick && um_q[0] && !rc_q[RC_TX_SEL] && !t2tx_q && qc_q >= 8'd4
         |-> $past(t1_ovf)) else $error("timer 1 tick without overflow");
   a_gen_stopped:
      assert property (um_q[0] && rc_q[RC_TX_SEL] && !rc_q[RC_RUN] && qc_q >= 8'd4 |-> !tx_tick)
         else $error("tick while generator stopped");
endmodule : ubr_rate_gen_chk

bind ubr_rate_gen ubr_rate_gen_chk chk (.ref_clk(ref_clk), .rst(rst), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .t1_ovf(t1_ovf), .tx_tick(tx_tick));

// ### ubr_rate_gen_tb.sv
// self-checking testbench of the serial bit-rate generator
`timescale 1ns/1ps
module ubr_rate_gen_tb
   import ubr_pkg::*;
();
   typedef struct {
      logic [3:0] um;
      logic pc;
      logic [4:0] rc;
      logic [7:0] t2c;
      logic [7:0] rl;
      int tx;
      int rx;
   } ubr_row_t;
   // mode, doubler, rate control, timer 2 control, reload -> tx and rx tick periods
   ubr_row_t rows [13] = '{
      '{4'h2, 1'b0, 5'h00, 8'h00, 8'h00, 32, 32},
      '{4'h2, 1'b1, 5'h00, 8'h00, 8'h00, 16, 16},
      '{4'h8, 1'b0, 5'h00, 8'h00, 8'h00, 4, 4},
      '{4'h0, 1'b1, 5'h00, 8'h00, 8'h00, 3, 3},
      '{4'h4, 1'b0, 5'h00, 8'h00, 8'h00, 8, 8},
      '{4'h4, 1'b1, 5'h00, 8'h00, 8'h00, 4, 4},
      '{4'h1, 1'b0, 5'h00, 8'h00, 8'h00, 64, 64},
      '{4'h3, 1'b1, 5'h00, 8'h00, 8'h00, 32, 32},
      '{4'h1, 1'b0, 5'h00, 8'h11, 8'h00, 32, 64},
      '{4'h1, 1'b1, 5'h00, 8'h31, 8'h00, 32, 32},
      '{4'h1, 1'b0, 5'h16, 8'h31, 8'hfd, 32, 96},
      '{4'h1, 1'b1, 5'h1c, 8'h00, 8'hff, 96, 96},
      '{4'h0, 1'b0, 5'h13, 8'h00, 8'hfe, 4, 4}};
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic t1_ovf = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] rd;
   logic hreadyout, hresp, tx_tick, rx_tick;
   logic [31:0] hrdata;
   int tx_gap, rx_gap, tx_n, n0;
   int n_mismatch = 0;
   int comparisons = 0;
   always #12.5 ref_clk = !ref_clk;
   // timer 1 auto-reloading from fe with no prescale: overflow every second clock
   always @(posedge ref_clk) t1_ovf <= !rst && !t1_ovf;
   ubr_rate_gen dut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .t1_ovf(t1_ovf),
      .tx_tick(tx_tick), .rx_tick(rx_tick));
   ubr_shift_model far (.ref_clk(ref_clk), .rst(rst), .tx_tick(tx_tick), .rx_tick(rx_tick),
      .tx_gap(tx_gap), .rx_gap(rx_gap), .tx_n(tx_n));
   // ------------------------------------------------------------
   // bus cycles and comparison
   // ------------------------------------------------------------
   // ready and read data are taken at the rising edge that ends the phase
   task automatic wait_ready();
      do begin
         @(posedge ref_clk);
      end while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : wait_ready
   task automatic bus(input logic w, input logic [7:0] ix, input logic [31:0] wd);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {22'h0, ix, 2'h0};
      hwrite <= w;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
   endtask : bus
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wrap_up();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (90000) @(posedge ref_clk);
      n_mismatch++;
      wrap_up();
   end
   initial begin
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      bus(1'b1, IDX_T2_RELOAD_LOW, 32'hfe);
      bus(1'b1, IDX_T2_RELOAD_HIGH, 32'hff);
      // timer 2 starts from zero: let it wrap once so it sits in the reload range
      bus(1'b1, IDX_T2_CTRL, 32'h11);
      repeat (65600) @(posedge ref_clk);
      bus(1'b0, IDX_T2_COUNT_HIGH, 32'h0);
      chk("timer 2 count high", rd, 32'hff);
      foreach (rows[i]) begin
         bus(1'b1, IDX_RATE_RELOAD, {24'h0, rows[i].rl});
         bus(1'b1, IDX_T2_CTRL, {24'h0, rows[i].t2c});
         bus(1'b1, IDX_UART_MODE, {28'h0, rows[i].um});
         bus(1'b1, IDX_POWER_CTRL, {24'h0, rows[i].pc, 7'h0});
         bus(1'b1, IDX_RATE_CTRL, {27'h0, rows[i].rc});
         repeat (700) @(posedge ref_clk);
         chk("tx period", 32'(tx_gap), 32'(rows[i].tx));
         chk("rx period", 32'(rx_gap), 32'(rows[i].rx));
      end
      // generator selected but not running gives no ticks
      bus(1'b1, IDX_UART_MODE, 32'h1);
      bus(1'b1, IDX_RATE_CTRL, 32'h08);
      // let a tick launched under the old source drain first
      repeat (4) @(posedge ref_clk);
      n0 = tx_n;
      repeat (300) @(posedge ref_clk);
      chk("ticks while stopped", 32'(tx_n - n0), 32'h0);
      // reset in mid-run, then the register map
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      bus(1'b0, IDX_RATE_RELOAD, 32'h0);
      chk("reload after reset", rd, 32'h0);
      bus(1'b0, IDX_RATE_CTRL, 32'h0);
      chk("control after reset", rd, 32'h0);
      bus(1'b1, IDX_RATE_COUNT, 32'hff);
      bus(1'b0, IDX_RATE_COUNT, 32'h0);
      chk("count read-only", rd, 32'h0);
      bus(1'b1, IDX_RATE_CTRL, 32'hff);
      bus(1'b0, IDX_RATE_CTRL, 32'h0);
      chk("control reserved bits", rd, 32'h1f);
      bus(1'b1, IDX_RATE_RELOAD, 32'hffff_fff5);
      bus(1'b0, IDX_RATE_RELOAD, 32'h0);
      chk("reload write", rd, 32'hf5);
      bus(1'b0, 8'h00, 32'h0);
      chk("unmapped read", rd, 32'h0);
      wrap_up();
   end
endmodule : ubr_rate_gen_tb

// ### ubr_rate_gen_unused_check.sv
// spare file: holds no logic, all port checks sit in the bound checker

// ### ubr_shift_model.sv
// model of the serial shifters that consume the bit-rate ticks
`timescale 1ns/1ps
module ubr_shift_model (
   input wire logic ref_clk, // system clock
   input wire logic rst, // synchronous reset
   input wire logic tx_tick, // transmit tick
   input wire logic rx_tick, // receive tick
   output int tx_gap, // clocks between the last two transmit ticks
   output int rx_gap, // clocks between the last two receive ticks
   output int tx_n // transmit ticks taken
);
   int tx_age;
   int rx_age;
   always @(posedge ref_clk) begin
      tx_age <= (rst || tx_tick) ? 1 : tx_age + 1;
      rx_age <= (rst || rx_tick) ? 1 : rx_age + 1;
      tx_n <= rst ? 0 : tx_n + int'(tx_tick);
      if (tx_tick) tx_gap <= tx_age;
      if (rx_tick) rx_gap <= rx_age;
   end
endmodule : ubr_shift_model
